// file: include/irwd_consts.vh
// Constants of the infrared remote-control wake-up decoder
`ifndef IRWD_CONSTS_VH
`define IRWD_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define IRWD_IDX_CTRL      6'h13
`define IRWD_IDX_ADDR      6'h15
`define IRWD_IDX_AMASK     6'h16
`define IRWD_IDX_RXADDR    6'h17
`define IRWD_IDX_R0L       6'h18
`define IRWD_IDX_R0H       6'h19
`define IRWD_IDX_R1L       6'h1A
`define IRWD_IDX_R1H       6'h1B
`define IRWD_IDX_R2L       6'h1C
`define IRWD_IDX_R2H       6'h1D
`define IRWD_IDX_R3L       6'h1E
`define IRWD_IDX_R3H       6'h1F
`define IRWD_IDX_STATUS    6'h20
`define IRWD_IDX_IMASK     6'h21
`define IRWD_IDX_SWRST     6'h22

// Reset values
`define IRWD_RST_CTRL      8'h00
`define IRWD_RST_ADDR      8'h00
`define IRWD_RST_AMASK     8'hE0
`define IRWD_RST_RXADDR    8'h00
`define IRWD_RST_R0L       5'h10
`define IRWD_RST_R0H       5'h14
`define IRWD_RST_R1L       5'h07
`define IRWD_RST_R1H       5'h0B
`define IRWD_RST_R2L       8'h50
`define IRWD_RST_R2H       8'h64
`define IRWD_RST_R3L       8'h28
`define IRWD_RST_R3H       8'h32
`define IRWD_RST_STATUS    8'h00
`define IRWD_RST_IMASK     8'h00

// Control fields
`define IRWD_CTRL_EN       0
`define IRWD_CTRL_INV      2
`define IRWD_CTRL_SEL      3
`define IRWD_CTRL_PROTO_LO 4
`define IRWD_CTRL_PROTO_HI 5
`define IRWD_PROTO_RC5     2'h0
`define IRWD_PROTO_PD      2'h1
`define IRWD_CTRL_WMASK    8'h3D

// Status, interrupt mask and soft reset fields
`define IRWD_STS_IR        5
`define IRWD_SWRST_BIT     0

// Timing: clock period and measurement unit
`define IRWD_CLK_PERIOD_NS 10
`define IRWD_TICK_NS       100000
// Clock cycles in one 0.1 ms tick; sized so the tick parameter takes it whole
`define IRWD_TICK_CYCLES   16'h2710

// Message framing
`define IRWD_RC5_LAST_HALF 5'd27
`define IRWD_RC5_ADDR_FIRST 4'd3
`define IRWD_RC5_ADDR_LAST 4'd7
`define IRWD_PD_LAST_BIT   6'd31
`define IRWD_PD_ADDR_BITS  6'd8

`endif

// file: logic/irwd_tick.v
// Tick prescaler and saturating segment-duration counter
`timescale 1ns/1ns
`default_nettype none

module irwd_tick #(
	parameter [15:0] TICK_CYCLES = 16'h2710
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       clr,
	output reg  [7:0] dur_q,
	output wire       sat
);

	localparam [15:0] TICK_LAST = TICK_CYCLES - 16'h0001; // Last prescaler count

	reg [15:0] pre_q; // Prescaler count within one tick

	// Full count means the segment is longer than any window can hold
	assign sat = (dur_q == 8'hFF);

	// Edge restarts both counters so each segment is measured from zero
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 16'h0000;
			dur_q <= 8'h00;
		end else if (ce) begin
			if (clr) begin
				pre_q <= 16'h0000;
				dur_q <= 8'h00;
			end else if (pre_q == TICK_LAST) begin
				pre_q <= 16'h0000;
				if (!sat) begin
					dur_q <= dur_q + 8'h01;
				end
			end else begin
				pre_q <= pre_q + 16'h0001;
			end
		end
	end

endmodule // irwd_tick

`default_nettype wire

// file: logic/irwd_top.v
// Infrared remote-control wake-up decoder with Avalon-MM register slave
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "irwd_consts.vh"

// Behaviour
// - Protocol field picks RC-5, pulse-distance, or nothing
// - Control bit 3 selects receive input B
// - Control bit 2 inverts the selected input
// - Disabled decoder never sets the IR status
// - Interrupt mask never gates IR status
// - Enabled address match sets status bit 5
// - Mask one excludes an address bit
// - Received address shifts into read-only register
// - Limits count 0.1 ms units
// - RC-5 full cell within range 0
// - Pulse-distance zero interval within range 0
// - Range 0 limits five bits, rest zero
// - Reset restores mask E0h, others defaults
// - RC-5 half cell, one interval: range 1
// - Pulse-distance header within range 2
// - Pulse-distance gap within range 3
module irwd_top #(
	parameter [15:0] TICK_CYCLES = `IRWD_TICK_CYCLES
) (
	input  wire        CLK_SYS,
	input  wire        RSTN,
	input  wire        CE,
	input  wire [7:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output wire [31:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	input  wire        IR_RECEIVE_INPUT_A,
	input  wire        IR_RECEIVE_INPUT_B,
	output wire        IRQ
);

	// One-hot decoder states
	localparam [4:0] ST_IDLE = 5'h01; // Waiting for a mark start
	localparam [4:0] ST_RC5  = 5'h02; // Manchester halves
	localparam [4:0] ST_HDR  = 5'h04; // Header mark
	localparam [4:0] ST_GAP  = 5'h08; // Post-header gap
	localparam [4:0] ST_DATA = 5'h10; // Pulse-distance bits

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	reg  [1:0] rst_sync_q;   // Reset release pipeline
	wire       rst_n;        // Synchronised reset for the rest of the block
	reg  [1:0] rx_meta_q;    // First stage, read only by second stage
	reg  [1:0] rx_sync_q;    // Second stage, safe for logic

	assign rst_n = rst_sync_q[1];

	// Asserts at once, releases two edges later
	always @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// Receiver pins are asynchronous to the clock
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			rx_meta_q <= 2'h3;
			rx_sync_q <= 2'h3;
		end else if (CE) begin
			rx_meta_q <= {IR_RECEIVE_INPUT_B, IR_RECEIVE_INPUT_A};
			rx_sync_q <= rx_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	reg  [7:0] ctrl_q;       // ir_wake_control
	reg  [7:0] waddr_q;      // ir_wake_address
	reg  [7:0] amask_q;      // ir_wake_address_mask
	reg  [7:0] rxaddr_q;     // ir_received_address
	reg  [4:0] r0l_q;        // Range 0 low limit
	reg  [4:0] r0h_q;        // Range 0 high limit
	reg  [4:0] r1l_q;        // Range 1 low limit
	reg  [4:0] r1h_q;        // Range 1 high limit
	reg  [7:0] r2l_q;        // Range 2 low limit
	reg  [7:0] r2h_q;        // Range 2 high limit
	reg  [7:0] r3l_q;        // Range 3 low limit
	reg  [7:0] r3h_q;        // Range 3 high limit
	reg  [7:0] status_q;     // wake_status_0, write one to clear
	reg  [7:0] imask_q;      // wake_enable_0, interrupt mask
	reg        ack_q;        // Second cycle of a bus access
	reg  [31:0] rdata_q;     // Registered read data
	reg  [7:0] rdata_d;      // Read mux result

	wire [5:0] idx = AVS_ADDRESS[7:2];        // Register index
	wire       req = AVS_READ | AVS_WRITE;    // Any bus request
	wire       wr  = AVS_WRITE & ack_q & AVS_BYTEENABLE[0]; // Committing write
	wire [7:0] wd  = AVS_WRITEDATA[7:0];      // Low lane only
	wire       sw_rst = wr & (idx == `IRWD_IDX_SWRST) & wd[`IRWD_SWRST_BIT];
	wire       ir_event;                       // Address match pulse

	// One wait state: the request is answered on the second edge
	assign AVS_WAITREQUEST = req & ~ack_q;
	assign AVS_READDATA    = rdata_q;
	// Level interrupt, enable register gates only this output
	assign IRQ = |(status_q & imask_q);

	// Read mux; narrow and reserved bits read zero, unmapped reads zero
	always @* begin
		rdata_d = 8'h00;
		case (idx)
			`IRWD_IDX_CTRL:   rdata_d = ctrl_q;
			`IRWD_IDX_ADDR:   rdata_d = waddr_q;
			`IRWD_IDX_AMASK:  rdata_d = amask_q;
			`IRWD_IDX_RXADDR: rdata_d = rxaddr_q;
			`IRWD_IDX_R0L:    rdata_d = {3'h0, r0l_q};
			`IRWD_IDX_R0H:    rdata_d = {3'h0, r0h_q};
			`IRWD_IDX_R1L:    rdata_d = {3'h0, r1l_q};
			`IRWD_IDX_R1H:    rdata_d = {3'h0, r1h_q};
			`IRWD_IDX_R2L:    rdata_d = r2l_q;
			`IRWD_IDX_R2H:    rdata_d = r2h_q;
			`IRWD_IDX_R3L:    rdata_d = r3l_q;
			`IRWD_IDX_R3H:    rdata_d = r3h_q;
			`IRWD_IDX_STATUS: rdata_d = status_q;
			`IRWD_IDX_IMASK:  rdata_d = imask_q;
			default:          rdata_d = 8'h00;
		endcase
	end

	// Bus handshake; read data captured one edge before it is taken
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (CE) begin
			ack_q <= req & ~ack_q;
			if (AVS_READ & ~ack_q) begin
				rdata_q <= {24'h00_0000, rdata_d};
			end
		end
	end

	// Software registers; soft reset restores the same defaults as power-up except the interrupt mask, which it leaves unchanged
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q  <= `IRWD_RST_CTRL;
			waddr_q <= `IRWD_RST_ADDR;
			amask_q <= `IRWD_RST_AMASK;
			r0l_q   <= `IRWD_RST_R0L;
			r0h_q   <= `IRWD_RST_R0H;
			r1l_q   <= `IRWD_RST_R1L;
			r1h_q   <= `IRWD_RST_R1H;
			r2l_q   <= `IRWD_RST_R2L;
			r2h_q   <= `IRWD_RST_R2H;
			r3l_q   <= `IRWD_RST_R3L;
			r3h_q   <= `IRWD_RST_R3H;
			imask_q <= `IRWD_RST_IMASK;
		end else if (CE) begin
			if (sw_rst) begin
				ctrl_q  <= `IRWD_RST_CTRL;
				waddr_q <= `IRWD_RST_ADDR;
				amask_q <= `IRWD_RST_AMASK;
				r0l_q   <= `IRWD_RST_R0L;
				r0h_q   <= `IRWD_RST_R0H;
				r1l_q   <= `IRWD_RST_R1L;
				r1h_q   <= `IRWD_RST_R1H;
				r2l_q   <= `IRWD_RST_R2L;
				r2h_q   <= `IRWD_RST_R2H;
				r3l_q   <= `IRWD_RST_R3L;
				r3h_q   <= `IRWD_RST_R3H;
			end else if (wr) begin
				case (idx)
					`IRWD_IDX_CTRL:  ctrl_q  <= wd & `IRWD_CTRL_WMASK;
					`IRWD_IDX_ADDR:  waddr_q <= wd;
					`IRWD_IDX_AMASK: amask_q <= wd;
					`IRWD_IDX_R0L:   r0l_q   <= wd[4:0];
					`IRWD_IDX_R0H:   r0h_q   <= wd[4:0];
					`IRWD_IDX_R1L:   r1l_q   <= wd[4:0];
					`IRWD_IDX_R1H:   r1h_q   <= wd[4:0];
					`IRWD_IDX_R2L:   r2l_q   <= wd;
					`IRWD_IDX_R2H:   r2h_q   <= wd;
					`IRWD_IDX_R3L:   r3l_q   <= wd;
					`IRWD_IDX_R3H:   r3h_q   <= wd;
					`IRWD_IDX_IMASK: imask_q <= wd;
					default: begin
						// Read-only and unmapped: write ignored
					end
				endcase
			end
		end
	end

	// Sticky status; a match in the clearing cycle survives the clear
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= `IRWD_RST_STATUS;
		end else if (CE) begin
			if (wr && idx == `IRWD_IDX_STATUS) begin
				status_q <= status_q & ~wd;
			end
			if (ir_event) begin
				status_q[`IRWD_STS_IR] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input selection and edge detection

	wire       enabled = ctrl_q[`IRWD_CTRL_EN];
	wire [1:0] proto   = ctrl_q[`IRWD_CTRL_PROTO_HI:`IRWD_CTRL_PROTO_LO];
	wire       rx_sel  = ctrl_q[`IRWD_CTRL_SEL] ? rx_sync_q[1] : rx_sync_q[0];
	// Receiver idles high and pulls low during a burst
	wire       mark_now = ~(rx_sel ^ ctrl_q[`IRWD_CTRL_INV]);
	reg        mark_q;       // Level one cycle earlier
	wire       rise = mark_now & ~mark_q; // Burst starts
	wire       fall = ~mark_now & mark_q; // Burst ends
	wire [7:0] dur;          // Ticks since the last edge
	wire       dur_sat;      // Segment too long for any window

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			mark_q <= 1'b0;
		end else if (CE) begin
			mark_q <= mark_now;
		end
	end

	// Durations are counted in 0.1 ms ticks, matching the limit registers
	irwd_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk   (CLK_SYS),
		.rst_n (rst_n),
		.ce    (CE),
		.clr   (rise | fall),
		.dur_q (dur),
		.sat   (dur_sat)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decoder

	reg  [4:0] state_q;      // One-hot state
	reg  [4:0] half_q;       // RC-5 half-cell position
	reg  [5:0] bit_q;        // Pulse-distance bit count
	reg  [7:0] held_q;       // Mark width of current pulse-distance bit
	reg        done_q;       // Message complete pulse

	// Inclusive window test
	function in_win;
		input [7:0] d;
		input [7:0] lo;
		input [7:0] hi;
		begin
			in_win = (d >= lo) && (d <= hi);
		end
	endfunction

	wire [8:0] ival  = {1'b0, held_q} + {1'b0, dur}; // Pulse-to-pulse time
	wire [7:0] ival8 = ival[8] ? 8'hFF : ival[7:0];   // Saturated interval
	wire       rc_one = in_win(dur, {3'h0, r1l_q}, {3'h0, r1h_q});
	wire       rc_two = in_win(dur, {3'h0, r0l_q}, {3'h0, r0h_q});
	wire [4:0] half_d = half_q + (rc_one ? 5'd1 : 5'd2);
	wire [3:0] rc_bit = half_d[4:1]; // Bit index at a mid-cell edge
	wire       pd_zero = in_win(ival8, {3'h0, r0l_q}, {3'h0, r0h_q});
	wire       pd_one  = in_win(ival8, {3'h0, r1l_q}, {3'h0, r1h_q});
	// Mask bit one drops that bit from the compare
	wire       addr_hit = ((rxaddr_q ^ waddr_q) & ~amask_q) == 8'h00;

	// Status only sets while the decoder is enabled
	assign ir_event = done_q & enabled & addr_hit;

	// Decoder state machine; disabled or reserved protocol holds it idle
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= ST_IDLE;
			half_q   <= 5'd0;
			bit_q    <= 6'd0;
			held_q   <= 8'h00;
			done_q   <= 1'b0;
			rxaddr_q <= `IRWD_RST_RXADDR;
		end else if (CE) begin
			done_q <= 1'b0;
			if (sw_rst) begin
				state_q  <= ST_IDLE;
				rxaddr_q <= `IRWD_RST_RXADDR;
			end else if (!enabled) begin
				state_q <= ST_IDLE;
			end else if (dur_sat && state_q != ST_IDLE) begin
				state_q <= ST_IDLE;
			end else begin
				case (state_q)
					ST_IDLE: begin
						// First burst is the mid-point of the RC-5 start bit
						if (rise && proto == `IRWD_PROTO_RC5) begin
							state_q  <= ST_RC5;
							half_q   <= 5'd1;
							rxaddr_q <= 8'h00;
						end else if (rise && proto == `IRWD_PROTO_PD) begin
							state_q  <= ST_HDR;
							rxaddr_q <= 8'h00;
						end
					end
					ST_RC5: begin
						if (rise | fall) begin
							// Full cell can only end at a mid-cell edge
							if ((!rc_one && !rc_two) || (!rc_one && !half_q[0])) begin
								state_q <= ST_IDLE;
							end else begin
								half_q <= half_d;
								// Burst in second half codes a one
								if (half_d[0] && rc_bit >= `IRWD_RC5_ADDR_FIRST
								    && rc_bit <= `IRWD_RC5_ADDR_LAST) begin
									rxaddr_q <= {rxaddr_q[6:0], rise};
								end
								if (half_d == `IRWD_RC5_LAST_HALF) begin
									done_q  <= 1'b1;
									state_q <= ST_IDLE;
								end
							end
						end
					end
					ST_HDR: begin
						if (fall) begin
							if (in_win(dur, r2l_q, r2h_q)) begin
								state_q <= ST_GAP;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_GAP: begin
						if (rise) begin
							if (in_win(dur, r3l_q, r3h_q)) begin
								state_q <= ST_DATA;
								bit_q   <= 6'd0;
								held_q  <= 8'h00;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_DATA: begin
						if (fall) begin
							held_q <= dur;
						end else if (rise) begin
							if (!pd_zero && !pd_one) begin
								state_q <= ST_IDLE;
							end else begin
								// Address byte arrives first, least significant bit first
								if (bit_q < `IRWD_PD_ADDR_BITS) begin
									rxaddr_q <= {pd_one & ~pd_zero, rxaddr_q[7:1]};
								end
								bit_q <= bit_q + 6'd1;
								if (bit_q == `IRWD_PD_LAST_BIT) begin
									done_q  <= 1'b1;
									state_q <= ST_IDLE;
								end
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule // irwd_top

`default_nettype wire

// file: testbench/irwd_ir_model.sv
// Behavioural infrared receiver that sends RC-5 or pulse-distance frames
`timescale 1ns/1ns
`default_nettype none
module irwd_ir_model #(
	parameter int TK = 4 // Clock cycles in one 0.1 ms tick
) (
	input  wire logic clk,
	output logic      out_a,
	output logic      out_b
);
	logic sel_q = 1'b0; // Pin that carries the frame
	logic inv_q = 1'b0; // Frame drawn with inverted polarity
	initial begin
		out_a = 1'b1;
		out_b = 1'b1;
	end
	////////////////////////////////////////
	// Mark (burst) or space for whole ticks; a mark is low before inversion
	task automatic hold(input logic mark, input int ticks);
		if (sel_q)
			out_b <= ~mark ^ inv_q;
		else
			out_a <= ~mark ^ inv_q;
		repeat (ticks * TK) @(posedge clk);
	endtask
	// Long space first: over 255 ticks, so any stray burst is dropped
	task automatic rc5(input logic s, input logic v, input logic [4:0] ad,
		input logic [5:0] cm, input int half);
		logic [13:0] w;
		sel_q = s;
		inv_q = v;
		w = {2'b11, 1'b0, ad, cm};
		hold(1'b0, 260);
		for (int i = 13; i >= 0; i--) begin
			hold(~w[i], half);
			hold(w[i], half);
		end
		hold(1'b0, 10);
	endtask
	// Header, gap, 32 intervals sent LSB first, then the stop burst
	task automatic pd(input logic s, input logic v, input logic [31:0] w, input int zero);
		sel_q = s;
		inv_q = v;
		hold(1'b0, 260);
		hold(1'b1, 90);
		hold(1'b0, 45);
		for (int i = 0; i < 32; i++) begin
			hold(1'b1, 5);
			hold(1'b0, (w[i] ? 22 : zero) - 5);
		end
		hold(1'b1, 5);
		hold(1'b0, 10);
	endtask
endmodule // irwd_ir_model
`default_nettype wire

// file: testbench/irwd_top_asserts.sv
// Port checker of the infrared wake-up decoder
`timescale 1ns/1ns
`default_nettype none
module irwd_top_asserts #(
	parameter [15:0] TICK_CYCLES = 16'h2710
) (
	input wire logic        CLK_SYS,
	input wire logic        RSTN,
	input wire logic        CE,
	input wire logic [7:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        IR_RECEIVE_INPUT_A,
	input wire logic        IR_RECEIVE_INPUT_B,
	input wire logic        IRQ
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	logic       live_q;  // Decoder left enabled with a usable scheme
	logic [3:0] since_q; // Cycles since a pin edge, saturating
	logic       a_q;     // Last pin levels
	logic       b_q;
	wire [5:0] idx = AVS_ADDRESS[7:2];
	wire wr_done = AVS_WRITE && !AVS_WAITREQUEST && CE && AVS_BYTEENABLE[0];
	wire rd_done = AVS_READ && !AVS_WAITREQUEST && CE;
	wire mwr = wr_done && idx == 6'h21; // Interrupt mask write lands
	////////////////////////////////////////
	// Helper state; soft reset also switches the decoder off
	always @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			live_q <= 1'b0;
			since_q <= 4'hF;
			a_q <= 1'b1;
			b_q <= 1'b1;
		end else begin
			a_q <= IR_RECEIVE_INPUT_A;
			b_q <= IR_RECEIVE_INPUT_B;
			if (IR_RECEIVE_INPUT_A != a_q || IR_RECEIVE_INPUT_B != b_q)
				since_q <= 4'h0;
			else if (since_q != 4'hF)
				since_q <= since_q + 4'h1;
			if (wr_done && idx == 6'h13)
				live_q <= AVS_WRITEDATA[0] && !AVS_WRITEDATA[5];
			else if (wr_done && idx == 6'h22 && AVS_WRITEDATA[0])
				live_q <= 1'b0;
		end
	end
	sequence s_new_req;
		(AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE);
	endsequence
	sequence s_irq_rise;
		$rose(IRQ) && !$past(mwr);
	endsequence
	property p_wait_first;
		s_new_req |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endproperty
	property p_ctrl_rsv;
		rd_done && idx == 6'h13 |-> AVS_READDATA[7:6] == 2'h0 && !AVS_READDATA[1];
	endproperty
	property p_lim_rsv;
		rd_done && (idx == 6'h18 || idx == 6'h19) |-> AVS_READDATA[7:5] == 3'h0;
	endproperty
	property p_irq_live;
		s_irq_rise |-> live_q;
	endproperty
	property p_irq_edge;
		s_irq_rise |-> since_q < 4'hC;
	endproperty
	property p_reset_quiet;
		$rose(RSTN) |-> !IRQ && AVS_READDATA == 32'h0;
	endproperty
	property p_clear;
		wr_done && idx == 6'h20 && AVS_WRITEDATA[5] |=> !IRQ;
	endproperty
	property p_mask_off;
		mwr && !AVS_WRITEDATA[5] |=> !IRQ;
	endproperty
	a_wait_first: assert property (p_wait_first)
		else $error("request not stalled for one cycle");
	a_ctrl_rsv: assert property (p_ctrl_rsv)
		else $error("control reserved bits not zero");
	a_lim_rsv: assert property (p_lim_rsv)
		else $error("limit upper bits not zero");
	a_irq_live: assert property (p_irq_live)
		else $error("interrupt while decoder off");
	a_irq_edge: assert property (p_irq_edge)
		else $error("interrupt not tied to a pin edge");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs not cleared by reset");
	a_clear: assert property (p_clear)
		else $error("status clear left interrupt high");
	a_mask_off: assert property (p_mask_off)
		else $error("masked interrupt still high");
endmodule // irwd_top_asserts
bind irwd_top irwd_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .IR_RECEIVE_INPUT_A(IR_RECEIVE_INPUT_A),
	.IR_RECEIVE_INPUT_B(IR_RECEIVE_INPUT_B), .IRQ(IRQ));
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench of the infrared wake-up decoder
`timescale 1ns/1ns
`default_nettype none
`include "irwd_consts.vh"
module tb_top;
	localparam int TK = 4; // Short tick keeps frames brief
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1; // Clock enable, dropped for one frame mode
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         irq;
	wire         ir_a;
	wire         ir_b;
	int          err_count = 0;
	int          comparisons = 0;
	logic [7:0]  rd; // Data of the last read
	always #5 clk_sys = ~clk_sys;
	irwd_top #(.TICK_CYCLES(16'h0004)) u_dut (
		.CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(4'h1), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .IR_RECEIVE_INPUT_A(ir_a),
		.IR_RECEIVE_INPUT_B(ir_b), .IRQ(irq));
	irwd_ir_model #(.TK(TK)) u_ir (.clk(clk_sys), .out_a(ir_a), .out_b(ir_b));
	////////////////////////////////////////
	// Verdict and end of run
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Byte compare, counted
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= {ix, 2'h0};
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			err_count++;
			end_of_test;
		end
	endtask
	task automatic wr(input logic [5:0] ix, input logic [7:0] d);
		bus(1'b1, ix, d);
	endtask
	task automatic rdc(input logic [5:0] ix, input logic [7:0] exp);
		bus(1'b0, ix, 8'h00);
		chk(rd, exp);
		chk({7'h0, |avs_readdata[31:8]}, 8'h00);
	endtask
	// Wake status expected after a frame
	function automatic logic [7:0] f_sts(input logic hit, input logic [7:0] rx,
		input logic [7:0] a, input logic [7:0] m);
		return (hit && ((rx ^ a) & ~m) == 8'h00) ? 8'h20 : 8'h00;
	endfunction
	////////////////////////////////////////
	// One frame; md 0 good, 1 off, 2 other pin, 3 bad timing, 4 reserved, 5 clock held
	task automatic trial(input int md);
		logic [31:0] r;
		logic [31:0] w;
		logic [7:0]  m;
		logic [7:0]  a;
		logic [7:0]  rx;
		logic [7:0]  sts;
		logic        pd;
		int          t;
		r = $urandom;
		w = $urandom;
		pd = r[2];
		w[31] = 1'b0;
		m = r[15:8] | (pd ? 8'h00 : 8'hE0);
		rx = pd ? w[7:0] : {3'h0, w[4:0]};
		a = r[3] ? rx ^ (r[23:16] & m) : r[31:24];
		t = (md == 3) ? (pd ? 16 : 13) : (pd ? 11 : 9);
		wr(`IRWD_IDX_R0L, pd ? 8'h09 : 8'h10);
		wr(`IRWD_IDX_R0H, pd ? 8'h0D : 8'h14);
		wr(`IRWD_IDX_R1L, pd ? 8'h14 : 8'h07);
		wr(`IRWD_IDX_R1H, pd ? 8'h19 : 8'h0B);
		wr(`IRWD_IDX_ADDR, a);
		wr(`IRWD_IDX_AMASK, m);
		wr(`IRWD_IDX_IMASK, {2'h0, r[4], 5'h00});
		wr(`IRWD_IDX_CTRL, {2'h0, md == 4, pd, r[0], r[1], 1'b0, md != 1});
		wr(`IRWD_IDX_STATUS, 8'h20);
		rdc(`IRWD_IDX_STATUS, 8'h00);
		chk({7'h0, irq}, 8'h00);
		// Frozen clock enable must leave the whole frame unseen
		ce <= (md != 5);
		if (pd)
			u_ir.pd(r[0] ^ (md == 2), r[1], w, t);
		else
			u_ir.rc5(r[0] ^ (md == 2), r[1], w[4:0], w[10:5], t);
		ce <= 1'b1;
		sts = f_sts(md == 0, rx, a, m);
		rdc(`IRWD_IDX_STATUS, sts);
		chk({7'h0, irq}, {7'h0, r[4] && sts[5]});
		if (md == 0)
			rdc(`IRWD_IDX_RXADDR, rx);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(49232));
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rdc(`IRWD_IDX_CTRL, 8'h00);
		rdc(`IRWD_IDX_ADDR, 8'h00);
		rdc(`IRWD_IDX_AMASK, 8'hE0);
		rdc(`IRWD_IDX_RXADDR, 8'h00);
		rdc(`IRWD_IDX_R0L, 8'h10);
		rdc(`IRWD_IDX_R0H, 8'h14);
		rdc(`IRWD_IDX_R1L, 8'h07);
		rdc(`IRWD_IDX_R2H, 8'h64);
		rdc(`IRWD_IDX_R3L, 8'h28);
		rdc(`IRWD_IDX_IMASK, 8'h00);
		wr(`IRWD_IDX_CTRL, 8'hFF);
		rdc(`IRWD_IDX_CTRL, 8'h3D);
		wr(`IRWD_IDX_R0H, 8'hFF);
		rdc(`IRWD_IDX_R0H, 8'h1F);
		wr(`IRWD_IDX_AMASK, 8'h00);
		wr(`IRWD_IDX_RXADDR, 8'h5A);
		rdc(`IRWD_IDX_RXADDR, 8'h00);
		rdc(6'h3F, 8'h00);
		wr(`IRWD_IDX_R3H, 8'h00);
		wr(`IRWD_IDX_SWRST, 8'h01);
		rdc(`IRWD_IDX_R3H, 8'h32);
		rdc(`IRWD_IDX_CTRL, 8'h00);
		rdc(`IRWD_IDX_AMASK, 8'hE0);
		rdc(`IRWD_IDX_R0H, 8'h14);
		for (int i = 0; i < 20; i++)
			trial(i < 8 ? 0 : i % 6);
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
